// *** timer2_pkg.sv ***
// Purpose: shared constants and types for the 8-bit crystal-capable timer
// Assumes: registers sit in a 256-byte window selected by hsel
// Notes:   one word per register, data in bits 7:0, upper bits read zero
package timer2_pkg;

	// ==========================================================
	// register map (byte addresses inside the window)
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CONTROL  = 8'h00;
	localparam logic [7:0]  OFS_COUNTER  = 8'h04;
	localparam logic [7:0]  OFS_COMPARE  = 8'h08;
	localparam logic [7:0]  OFS_STATUS   = 8'h0C;
	localparam logic [7:0]  OFS_FLAGS    = 8'h10;
	localparam logic [7:0]  OFS_ENABLE   = 8'h14;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [7:0]  CNT_MAX      = 8'hFF;

	// ==========================================================
	// field positions
	localparam int CS_LSB       = 0;
	localparam int CS_MSB       = 2;
	localparam int OMODE_LSB    = 4;
	localparam int OMODE_MSB    = 5;
	localparam int ASYNC_BIT    = 3;
	localparam int CNT_BUSY_BIT = 2;
	localparam int CMP_BUSY_BIT = 1;
	localparam int CTL_BUSY_BIT = 0;
	localparam int FLAG_CMP_BIT = 0;
	localparam int FLAG_OVF_BIT = 1;

	// ==========================================================
	// clock select codes and prescaler taps
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV32   = 3'h3;
	localparam logic [2:0] CS_DIV64   = 3'h4;
	localparam logic [2:0] CS_DIV128  = 3'h5;
	localparam logic [2:0] CS_DIV256  = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;
	localparam int         PSC_W      = 10;
	localparam logic [PSC_W-1:0] PSC_M8    = 10'h007;
	localparam logic [PSC_W-1:0] PSC_M32   = 10'h01F;
	localparam logic [PSC_W-1:0] PSC_M64   = 10'h03F;
	localparam logic [PSC_W-1:0] PSC_M128  = 10'h07F;
	localparam logic [PSC_W-1:0] PSC_M256  = 10'h0FF;
	localparam logic [PSC_W-1:0] PSC_M1024 = 10'h3FF;

	// output pin action on a match
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	// ==========================================================
	// timing
	localparam logic [1:0] LATCH_EDGES   = 2'h2;	// crystal edges to latch a write
	localparam int         FLAG_SYNC_CYC = 3;	// processor cycles of flag sync

	// ==========================================================
	// types
	typedef struct packed {
		logic                     compare_irq;
		logic                     overflow_irq;
	} irq_out_t;

	typedef struct packed {
		logic                     xs1;
		logic                     xs2;
		logic                     xs3;
		logic                     async_clock_select;
		logic [7:0]               ctl;
		logic [7:0]               ctl_hold;
		logic [7:0]               cnt;
		logic [7:0]               cnt_hold;
		logic [7:0]               cmp;
		logic [7:0]               cmp_hold;
		logic [7:0]               cnt_view;
		logic [1:0]               ctl_pend;
		logic [1:0]               cnt_pend;
		logic [1:0]               cmp_pend;
		logic [PSC_W-1:0]         psc;
		logic                     block_match;
		logic [FLAG_SYNC_CYC-1:0] cmp_pipe;
		logic [FLAG_SYNC_CYC-1:0] ovf_pipe;
		logic                     compare_match_flag;
		logic                     overflow_flag;
		logic                     compare_irq_enable;
		logic                     overflow_irq_enable;
		logic                     wave;
		logic                     dp_write;
		logic [ADDR_W-1:0]        dp_addr;
		logic [7:0]               rdata;
	} state_t;

endpackage

// *** timer2_core.sv ***
// Purpose: 8-bit timer with clock select, holding registers and crystal sync
// Assumes: hclk well above four times the crystal rate; crystal pin is async
// Notes:   zero-wait AHB-Lite slave, read data registered in the address phase
//
// Operation
// - clock select picks stop, undivided or prescaled tick
// - counter register reads and writes the count
// - counter write blocks match on next tick
// - compare register continuously matched against counter
// - async bit selects io clock or crystal
// - changing async bit leaves registers undefined
// - counter write sets busy until loaded
// - compare write sets busy until loaded
// - control write sets busy until loaded
// - counter reads live, others read holding register
// - own holding register, latched after two edges
// - pending counter or compare write blocks matches
// - interrupt logic needs one crystal cycle reset
// - wake starts on next timer tick
// - counter read view refreshed each crystal edge
// - async flag sync takes three cycles plus tick
// - output pin changes on timer tick only
// - match flag set by match, cleared by ack
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module timer2_core (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	input  wire logic                      crystal_input_pin,
	input  wire logic                      compare_irq_ack,
	input  wire logic                      overflow_irq_ack,
	output timer2_pkg::irq_out_t           irq,
	output logic                           waveform_output_pin
);
	import timer2_pkg::*;

	// ==========================================================
	// helpers

	// prescaler tap for the selected division
	function automatic logic prescale_hit(input logic [2:0] cs, input logic [PSC_W-1:0] p);
		logic hit;
		hit = 1'b0;
		case (cs)
			CS_STOP:    hit = 1'b0;
			CS_DIV1:    hit = 1'b1;
			CS_DIV8:    hit = ((p & PSC_M8) == PSC_M8);
			CS_DIV32:   hit = ((p & PSC_M32) == PSC_M32);
			CS_DIV64:   hit = ((p & PSC_M64) == PSC_M64);
			CS_DIV128:  hit = ((p & PSC_M128) == PSC_M128);
			CS_DIV256:  hit = ((p & PSC_M256) == PSC_M256);
			CS_DIV1024: hit = ((p & PSC_M1024) == PSC_M1024);
			default:    hit = 1'b0;
		endcase
		return hit;
	endfunction

	// register read decode
	function automatic logic [7:0] read_mux(input state_t s, input logic [ADDR_W-1:0] a);
		logic [7:0] v;
		v = RST_BYTE;
		case (a)
			OFS_CONTROL: v = s.ctl_hold;
			OFS_COMPARE: v = s.cmp_hold;
			OFS_COUNTER: v = s.async_clock_select ? s.cnt_view : s.cnt;
			OFS_STATUS: begin
				v[ASYNC_BIT]    = s.async_clock_select;
				v[CNT_BUSY_BIT] = (s.cnt_pend != 2'h0);
				v[CMP_BUSY_BIT] = (s.cmp_pend != 2'h0);
				v[CTL_BUSY_BIT] = (s.ctl_pend != 2'h0);
			end
			OFS_FLAGS: begin
				v[FLAG_CMP_BIT] = s.compare_match_flag;
				v[FLAG_OVF_BIT] = s.overflow_flag;
			end
			OFS_ENABLE: begin
				v[FLAG_CMP_BIT] = s.compare_irq_enable;
				v[FLAG_OVF_BIT] = s.overflow_irq_enable;
			end
			default: v = RST_BYTE;
		endcase
		return v;
	endfunction

	// ==========================================================
	// state

	state_t s_q;
	state_t s_d;

	logic       xedge;
	logic       src_tick;
	logic       tick;
	logic       match_ok;
	logic       cmp_evt;
	logic       ovf_evt;
	logic       cmp_set;
	logic       ovf_set;
	logic [1:0] omode;
	logic [7:0] wbyte;
	logic       addr_valid;

	// ==========================================================
	// next-state logic
	always_comb begin
		s_d        = s_q;
		wbyte      = hwdata[7:0];
		omode      = s_q.ctl[OMODE_MSB:OMODE_LSB];
		addr_valid = hsel && hready && htrans[1];

		// crystal pin synchroniser and rising edge
		s_d.xs1 = crystal_input_pin;
		s_d.xs2 = s_q.xs1;
		s_d.xs3 = s_q.xs2;
		xedge   = s_q.xs2 && !s_q.xs3;

		// source clock: io clock every cycle, or crystal edges
		src_tick = s_q.async_clock_select ? xedge : 1'b1;

		// prescaler and timer tick
		if (src_tick) begin
			s_d.psc = s_q.psc + 1'b1;
		end
		tick = src_tick && prescale_hit(s_q.ctl[CS_MSB:CS_LSB], s_q.psc);

		// match allowed only with no pending counter or compare load
		match_ok = !s_q.block_match && (s_q.cnt_pend == 2'h0)
			&& (s_q.cmp_pend == 2'h0);

		// counting and events
		cmp_evt = 1'b0;
		ovf_evt = 1'b0;
		if (tick) begin
			s_d.cnt         = s_q.cnt + 1'b1;
			s_d.block_match = 1'b0;
			ovf_evt         = (s_q.cnt == CNT_MAX);
			cmp_evt         = match_ok && (s_q.cnt == s_q.cmp);
		end

		// waveform pin acts on the tick itself, no resync
		if (cmp_evt) begin
			case (omode)
				OM_TOGGLE: s_d.wave = !s_q.wave;
				OM_CLEAR:  s_d.wave = 1'b0;
				OM_SET:    s_d.wave = 1'b1;
				default:   s_d.wave = s_q.wave;
			endcase
		end

		// async: events ride a short sync pipe before the flags
		s_d.cmp_pipe = {s_q.cmp_pipe[FLAG_SYNC_CYC-2:0], cmp_evt};
		s_d.ovf_pipe = {s_q.ovf_pipe[FLAG_SYNC_CYC-2:0], ovf_evt};
		cmp_set = s_q.async_clock_select ? s_q.cmp_pipe[FLAG_SYNC_CYC-1] : cmp_evt;
		ovf_set = s_q.async_clock_select ? s_q.ovf_pipe[FLAG_SYNC_CYC-1] : ovf_evt;

		// holding register transfers on crystal edges
		if (xedge && (s_q.cnt_pend != 2'h0)) begin
			s_d.cnt_pend = s_q.cnt_pend - 2'h1;
			if (s_q.cnt_pend == 2'h1) begin
				s_d.cnt         = s_q.cnt_hold;
				s_d.block_match = 1'b1;
			end
		end
		if (xedge && (s_q.cmp_pend != 2'h0)) begin
			s_d.cmp_pend = s_q.cmp_pend - 2'h1;
			if (s_q.cmp_pend == 2'h1) begin
				s_d.cmp = s_q.cmp_hold;
			end
		end
		if (xedge && (s_q.ctl_pend != 2'h0)) begin
			s_d.ctl_pend = s_q.ctl_pend - 2'h1;
			if (s_q.ctl_pend == 2'h1) begin
				s_d.ctl = s_q.ctl_hold;
			end
		end

		// counter read view follows every cycle, or only crystal edges in async mode, after any load lands
		if (!s_q.async_clock_select || xedge) begin
			s_d.cnt_view = s_d.cnt;
		end

		// flags: ack or write-one clears, set wins
		if (compare_irq_ack) begin
			s_d.compare_match_flag = 1'b0;
		end
		if (overflow_irq_ack) begin
			s_d.overflow_flag = 1'b0;
		end
		if (s_q.dp_write && (s_q.dp_addr == OFS_FLAGS)) begin
			if (wbyte[FLAG_CMP_BIT]) begin
				s_d.compare_match_flag = 1'b0;
			end
			if (wbyte[FLAG_OVF_BIT]) begin
				s_d.overflow_flag = 1'b0;
			end
		end
		if (cmp_set) begin
			s_d.compare_match_flag = 1'b1;
		end
		if (ovf_set) begin
			s_d.overflow_flag = 1'b1;
		end

		// bus data phase writes, after counting so a write wins
		if (s_q.dp_write) begin
			case (s_q.dp_addr)
				OFS_CONTROL: begin
					s_d.ctl_hold = wbyte;
					if (s_q.async_clock_select) begin
						s_d.ctl_pend = LATCH_EDGES;
					end else begin
						s_d.ctl = wbyte;
					end
				end
				OFS_COUNTER: begin
					s_d.cnt_hold = wbyte;
					if (s_q.async_clock_select) begin
						s_d.cnt_pend = LATCH_EDGES;
					end else begin
						s_d.cnt         = wbyte;
						s_d.cnt_view    = wbyte;
						s_d.block_match = 1'b1;
					end
				end
				OFS_COMPARE: begin
					s_d.cmp_hold = wbyte;
					if (s_q.async_clock_select) begin
						s_d.cmp_pend = LATCH_EDGES;
					end else begin
						s_d.cmp = wbyte;
					end
				end
				OFS_STATUS: begin
					// a source switch keeps stale contents, software rewrites
					s_d.async_clock_select = wbyte[ASYNC_BIT];
				end
				OFS_ENABLE: begin
					s_d.compare_irq_enable  = wbyte[FLAG_CMP_BIT];
					s_d.overflow_irq_enable = wbyte[FLAG_OVF_BIT];
				end
				default: begin
					s_d.dp_write = 1'b0;
				end
			endcase
		end

		// bus address phase capture and registered read data
		s_d.dp_write = addr_valid && hwrite;
		s_d.dp_addr  = haddr[ADDR_W-1:0];
		if (addr_valid && !hwrite) begin
			s_d.rdata = read_mux(s_q, haddr[ADDR_W-1:0]);
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs
	assign hreadyout            = 1'b1;			// zero wait states
	assign hresp                = 1'b0;			// always OKAY
	assign hrdata               = {24'h000000, s_q.rdata};
	assign waveform_output_pin  = s_q.wave;
	assign irq.compare_irq      = s_q.compare_match_flag && s_q.compare_irq_enable;
	assign irq.overflow_irq     = s_q.overflow_flag && s_q.overflow_irq_enable;

endmodule

// *** timer2_core_properties.sv ***
// Purpose: bus and flag checks on the timer ports
// Assumes: one clock domain, hready tied to hreadyout
// Notes:   offset 0x20 is unmapped
`timescale 1ns/1ps

module timer2_core_props (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic [31:0]          haddr,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic [2:0]           hsize,
	input wire logic [31:0]          hwdata,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic [31:0]          hrdata,
	input wire logic                 hresp,
	input wire logic                 crystal_input_pin,
	input wire logic                 compare_irq_ack,
	input wire logic                 overflow_irq_ack,
	input wire timer2_pkg::irq_out_t irq,
	input wire logic                 waveform_output_pin
);
	import timer2_pkg::*;
	logic rd_ap;
	logic wr_hit;
	logic wr_hit_q;

	// ==========================================
	// address phase decode
	assign rd_ap = hsel && hready && htrans[1] && !hwrite;
	assign wr_hit = hsel && hready && htrans[1] && hwrite
		&& (haddr[7:0] == OFS_FLAGS || haddr[7:0] == OFS_ENABLE);

	// flag or enable write in its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_hit_q <= 1'b0;
		else
			wr_hit_q <= wr_hit;
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ==========================================
	// assertions
	AST_ZERO_WAIT: assert property (hreadyout)
		else $error("slave inserted a wait state");
	AST_OKAY_RESP: assert property (hresp == 1'b0)
		else $error("slave gave a non okay response");
	AST_RDATA_UPPER: assert property (rd_ap |=> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	AST_UNMAPPED_RD: assert property (rd_ap && haddr[7:0] == 8'h20 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_STATUS_RD: assert property (rd_ap && haddr[7:0] == OFS_STATUS |=> hrdata[7:4] == 4'h0)
		else $error("status unused bits set");
	AST_RDATA_HOLD: assert property (!rd_ap |=> $stable(hrdata))
		else $error("read data changed without a read");
	AST_CMP_IRQ_HOLD: assert property ($fell(irq.compare_irq)
		|-> $past(compare_irq_ack) || $past(wr_hit_q))
		else $error("compare irq dropped without a clear");
	AST_OVF_IRQ_HOLD: assert property ($fell(irq.overflow_irq)
		|-> $past(overflow_irq_ack) || $past(wr_hit_q))
		else $error("overflow irq dropped without a clear");
endmodule

bind timer2_core timer2_core_props u_timer2_core_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .crystal_input_pin(crystal_input_pin), .compare_irq_ack(compare_irq_ack),
	.overflow_irq_ack(overflow_irq_ack), .irq(irq), .waveform_output_pin(waveform_output_pin));

// *** crystal_osc.sv ***
// Purpose: watch crystal stand-in, one rising edge per period while run
// Assumes: period well above four hclk periods
// Notes:   pin rests low while stopped
`timescale 1ns/1ps

module crystal_osc #(
	parameter int HALF_NS = 40
) (
	input  wire logic run,
	output logic      xtal
);
	// ==========================================
	// each period opens with a rising edge
	initial xtal = 1'b0;
	always begin
		wait (run);	// no edges until started, settle time elided
		xtal = 1'b1;
		#HALF_NS xtal = 1'b0;
		#HALF_NS;
	end
endmodule

// *** timer2_core_tb.sv ***
// Purpose: register level tests of the timer over the bus
// Assumes: crystal period is ten hclk periods
// Notes:   offset 0x20 is unmapped
`timescale 1ns/1ps

module timer2_core_tb;
	import timer2_pkg::*;
	logic        hclk, hresetn, hwrite, hreadyout, hresp, wave, ack_c, ack_o, xtal, run;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, r0;
	irq_out_t    irq;
	int          n_fail, n_tests;
	int unsigned divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};

	timer2_core u_timer2_core (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .crystal_input_pin(xtal),
		.compare_irq_ack(ack_c), .overflow_irq_ack(ack_o), .irq(irq),
		.waveform_output_pin(wave));
	crystal_osc u_crystal_osc (.run(run), .xtal(xtal));

	// ==========================================
	// clock, bus and check tasks
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// n crystal rising edges, stopped before the next period
	task automatic edges(input int n);
		run <= 1'b1;
		repeat (n * 10 - 5) @(posedge hclk);
		run <= 1'b0;
		repeat (15) @(posedge hclk);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================
	// tests
	initial begin
		hresetn = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ack_c = 1'b0;
		ack_o = 1'b0;
		run = 1'b0;
		n_fail = 0;
		n_tests = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) rdchk(ofs[i], 32'h0);
		$display("reset test done");
		// count over a whole number of prescaled periods
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, OFS_CONTROL, c);
			xfer(1'b0, OFS_COUNTER, 32'h0);
			r0 = rd;
			repeat ((c == 0 ? 8 : 8 * divs[c]) - 3) @(posedge hclk);
			xfer(1'b0, OFS_COUNTER, 32'h0);
			chk((rd - r0) & 32'hFF, c == 0 ? 32'h0 : 32'h8);
		end
		$display("prescaler test done");
		// match, flags, irq and pin toggle
		xfer(1'b1, OFS_CONTROL, 32'h0);
		xfer(1'b1, OFS_COUNTER, 32'h10);
		xfer(1'b1, OFS_COMPARE, 32'h14);
		xfer(1'b1, OFS_FLAGS, 32'h3);
		xfer(1'b1, OFS_ENABLE, 32'h3);
		xfer(1'b1, OFS_CONTROL, 32'h11);
		repeat (30) @(posedge hclk);
		chk({30'h0, irq}, 32'h2);
		chk({31'h0, wave}, 32'h1);
		rdchk(OFS_FLAGS, 32'h1);
		xfer(1'b1, OFS_FLAGS, 32'h1);
		repeat (2) @(posedge hclk);
		chk({30'h0, irq}, 32'h0);
		repeat (300) @(posedge hclk);
		chk({30'h0, irq}, 32'h3);
		ack_c <= 1'b1;
		ack_o <= 1'b1;
		@(posedge hclk);
		ack_c <= 1'b0;
		ack_o <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({30'h0, irq}, 32'h0);
		chk({31'h0, wave}, 32'h0);
		$display("compare test done");
		// counter write onto the compare value hides that match
		xfer(1'b1, OFS_CONTROL, 32'h0);
		xfer(1'b1, OFS_COUNTER, 32'h0);
		xfer(1'b1, OFS_COMPARE, 32'h80);
		xfer(1'b1, OFS_FLAGS, 32'h3);
		xfer(1'b1, OFS_CONTROL, 32'h1);
		xfer(1'b1, OFS_COUNTER, 32'h80);
		repeat (3) @(posedge hclk);
		rdchk(OFS_FLAGS, 32'h0);
		repeat (300) @(posedge hclk);
		rdchk(OFS_FLAGS, 32'h3);
		$display("match block test done");
		// crystal clocking, rewrite all three after the switch
		xfer(1'b1, OFS_CONTROL, 32'h0);
		xfer(1'b1, OFS_ENABLE, 32'h0);
		xfer(1'b1, OFS_STATUS, 32'h8);
		rdchk(OFS_STATUS, 32'h8);
		xfer(1'b1, OFS_COMPARE, 32'h55);
		xfer(1'b1, OFS_COUNTER, 32'h33);
		xfer(1'b1, OFS_CONTROL, 32'h0);
		rdchk(OFS_STATUS, 32'hF);
		edges(1);
		rdchk(OFS_STATUS, 32'hF);
		edges(1);
		rdchk(OFS_STATUS, 32'h8);
		rdchk(OFS_COMPARE, 32'h55);
		edges(1); // no write while busy
		rdchk(OFS_COUNTER, 32'h33);
		$display("async test done");
		// crystal counting: pending compare hides a match, then set and clear
		xfer(1'b1, OFS_FLAGS, 32'h3);
		xfer(1'b1, OFS_COMPARE, 32'h34);
		xfer(1'b1, OFS_CONTROL, 32'h31);
		edges(2);
		xfer(1'b1, OFS_COMPARE, 32'h34);
		edges(2);
		rdchk(OFS_FLAGS, 32'h0);
		chk({31'h0, wave}, 32'h0);
		edges(256);
		rdchk(OFS_FLAGS, 32'h3);
		chk({31'h0, wave}, 32'h1);
		rdchk(OFS_COUNTER, 32'h35);
		xfer(1'b1, OFS_FLAGS, 32'h3);
		xfer(1'b1, OFS_CONTROL, 32'h21);
		edges(256);
		rdchk(OFS_FLAGS, 32'h3);
		chk({31'h0, wave}, 32'h0);
		$display("crystal count test done");
		conclude();
	end

	// hang guard
	initial begin
		repeat (40000) @(posedge hclk);
		n_fail++;
		conclude();
	end
endmodule
